// *** rtl/master_spi_mode_baud_gen.sv ***
// Purpose: half-period tick generator for the serial clock
// Assumes: reload arrives in the same cycle in which the divisor register first holds its new value
// Notes:   one tick every divisor+1 cycles, so the serial clock runs at core/(2*(divisor+1))
`default_nettype none

module spim_baud_gen
    import spim_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [BAUD_W-1:0] baud,
    input  wire logic              reload,
    output var  logic              tick
);

    logic [BAUD_W-1:0] cnt_q;
    logic [BAUD_W-1:0] cnt_d;
    logic              tick_q;
    logic              tick_d;

    ////////////////////////////////////////////////////////////////////////////////
    // down counter, reloaded at zero or on a low-byte write
    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (reload) begin
            cnt_d = baud;
        end else if (cnt_q == BAUD_RESET) begin
            cnt_d  = baud;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q - BAUD_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q  <= BAUD_RESET;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    a_reload_takes : assert property (@(posedge clk) disable iff (!rst_n)
        (reload && clk_en) |=> (cnt_q == $past(baud)))
        else $error("prescaler not reloaded on low byte write");

endmodule

`default_nettype wire

// *** rtl/master_spi_mode_pkg.sv ***
// Purpose: shared constants, types and helpers for the master-only serial SPI engine
// Assumes: one 100 MHz core clock, all control bits arrive as plain ports
// Notes:   frame layout and bit-order helpers are used by the engine only; the receive buffer takes the count and reset constants
`default_nettype none

package spim_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // frame and clocking constants
    localparam int          DATA_BITS       = 8;
    localparam int          BAUD_W          = 12;
    localparam int          EDGE_W          = 4;
    localparam logic [3:0]  FIRST_EDGE      = 4'h0;
    localparam logic [3:0]  LAST_EDGE       = 4'hf;
    localparam logic [3:0]  EDGE_STEP       = 4'h1;
    localparam logic [1:0]  MODE_SPI_MASTER = 2'b11;
    localparam logic [11:0] BAUD_RESET      = 12'h000;
    localparam logic [11:0] BAUD_ONE        = 12'h001;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam int          BAUD_LO_W       = 8;
    localparam int          BAUD_HI_W       = 4;
    localparam logic [1:0]  RX_EMPTY        = 2'h0;
    localparam logic [1:0]  RX_ONE          = 2'h1;
    localparam logic [1:0]  RX_FULL         = 2'h2;
    localparam int          CORE_CLK_MHZ    = 100;

    ////////////////////////////////////////////////////////////////////////////////
    // shifter states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // bit at the head of the shifter for the selected order
    function automatic logic first_bit(input logic [7:0] data, input logic lsb_first);
        first_bit = lsb_first ? data[0] : data[DATA_BITS-1];
    endfunction

    // move the shifter one place toward the outgoing end
    function automatic logic [7:0] shift_out(input logic [7:0] data, input logic lsb_first);
        shift_out = lsb_first ? {1'b0, data[7:1]} : {data[6:0], 1'b0};
    endfunction

    // enter one sampled bit at the far end so the byte lands in natural order
    function automatic logic [7:0] shift_in(input logic [7:0] data, input logic bit_in,
                                            input logic lsb_first);
        shift_in = lsb_first ? {bit_in, data[7:1]} : {data[6:0], bit_in};
    endfunction

endpackage

`default_nettype wire

// *** rtl/master_spi_mode_rx_buffer.sv ***
// Purpose: receive buffer, one level beyond the receive shifter plus the readable head
// Assumes: push and pop are single-cycle strobes
// Notes:   a push into a full buffer is dropped so the oldest bytes survive
`default_nettype none

module spim_rx_buffer
    import spim_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       flush,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    input  wire logic       pop,
    output var  logic [7:0] head,
    output var  logic       not_empty
);

    logic [7:0] head_q;
    logic [7:0] head_d;
    logic [7:0] tail_q;
    logic [7:0] tail_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic       ne_q;
    logic       do_pop;

    ////////////////////////////////////////////////////////////////////////////////
    // two-entry queue with a registered head
    always_comb begin
        head_d = head_q;
        tail_d = tail_q;
        cnt_d  = cnt_q;
        do_pop = pop && (cnt_q != RX_EMPTY);
        if (do_pop) begin
            head_d = tail_q;
            cnt_d  = cnt_q - RX_ONE;
        end
        if (push) begin
            if (cnt_d == RX_EMPTY) begin
                head_d = push_data;
                cnt_d  = RX_ONE;
            end else if (cnt_d == RX_ONE) begin
                tail_d = push_data;
                cnt_d  = RX_FULL;
            end
            // full: newest byte is lost, stored bytes untouched
        end
        if (flush) begin
            cnt_d = RX_EMPTY;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            head_q <= BYTE_RESET;
            tail_q <= BYTE_RESET;
            cnt_q  <= RX_EMPTY;
            ne_q   <= 1'b0;
        end else if (clk_en) begin
            head_q <= head_d;
            tail_q <= tail_d;
            cnt_q  <= cnt_d;
            ne_q   <= (cnt_d != RX_EMPTY);
        end
    end

    assign head      = head_q;
    assign not_empty = ne_q;

    a_overflow_keeps_old : assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && push && !pop && !flush && cnt_q == RX_FULL) |=> (head_q == $past(head_q)
            && tail_q == $past(tail_q) && cnt_q == RX_FULL))
        else $error("overflow overwrote buffered data");

endmodule

`default_nettype wire

// *** rtl/master_spi_mode_top.sv ***
// Purpose: master-only SPI engine built on the serial port's buffers and baud generator
// Assumes: control bits are plain ports; data, baud and flag accesses are single-cycle strobes
// Notes:   no slave select exists; chip select is left to general-purpose pins
//
// Overview of operation
// - one frame is eight data bits only
// - one order bit steers transmit and receive
// - queued data follows at once, else line high
// - two writes give sixteen bits, one completion
// - transmitter must be on; receiver optional
// - transmit enable takes over the output pin
// - receive enable takes over the input pin
// - transmitter drives transfer clock in both cases
// - data write starts every transfer, no write no clock
// - buffered byte loads when shifter frees up
// - overflow drops newest byte, keeps oldest
// - receive has extra level; transmit double buffered
// - usual flags work; error flags read zero
// - baud divisor resets to zero
// - no slave select, master only
// - no collision flag, no double-speed bit
// - mode field both ones selects this mode
// - clock is core over two times divisor plus one
// - polarity and phase pick four modes, opposite edges
// - low byte write reloads the prescaler at once
`default_nettype none

module spim_top
    import spim_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    input  wire logic       CLK_EN,
    input  wire logic [1:0] PORT_MODE_SELECT,
    input  wire logic       TRANSMITTER_ENABLE,
    input  wire logic       RECEIVER_ENABLE,
    input  wire logic       BIT_ORDER_SELECT,
    input  wire logic       CLOCK_POLARITY_BIT,
    input  wire logic       CLOCK_PHASE_BIT,
    input  wire logic       CLOCK_PIN_DIRECTION,
    input  wire logic       BAUD_WR_LOW,
    input  wire logic       BAUD_WR_HIGH,
    input  wire logic [7:0] BAUD_WDATA,
    input  wire logic       DATA_WRITE,
    input  wire logic [7:0] DATA_WDATA,
    input  wire logic       DATA_READ,
    input  wire logic       TXC_CLEAR,
    input  wire logic       SERIAL_IN_PIN,
    output var  logic [7:0] DATA_RDATA,
    output var  logic       RECEIVE_COMPLETE_FLAG,
    output var  logic       TRANSMIT_COMPLETE_FLAG,
    output var  logic       DATA_REG_EMPTY_FLAG,
    output var  logic       FRAMING_ERROR_FLAG,
    output var  logic       OVERRUN_ERROR_FLAG,
    output var  logic       PARITY_ERROR_FLAG,
    output var  logic       SERIAL_OUT_PIN,
    output var  logic       SERIAL_OUT_OE,
    output var  logic       SERIAL_IN_SELECT,
    output var  logic       TRANSFER_CLOCK_PIN,
    output var  logic       TRANSFER_CLOCK_OE
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [BAUD_W-1:0] baud_q;
    logic [BAUD_W-1:0] baud_d;
    logic              reload_q;
    logic              tick;
    shift_state_t      state_q;
    shift_state_t      state_d;
    logic [EDGE_W-1:0] edge_q;
    logic [EDGE_W-1:0] edge_d;
    logic [7:0]        tx_sh_q;
    logic [7:0]        tx_sh_d;
    logic [7:0]        rx_sh_q;
    logic [7:0]        rx_sh_d;
    logic [7:0]        txbuf_q;
    logic [7:0]        txbuf_d;
    logic              txfull_q;
    logic              txfull_d;
    logic              txc_q;
    logic              txc_d;
    logic              sclk_q;
    logic              sclk_d;
    logic              sdo_q;
    logic              sdo_d;
    logic              out_oe_q;
    logic              in_sel_q;
    logic              clk_oe_q;
    logic              udre_q;
    logic              err_q;
    logic              mode_on;
    logic              active;
    logic              leading;
    logic              sample;
    logic              push;
    logic              load;

    // mode field both ones puts the port in this mode
    assign mode_on = (PORT_MODE_SELECT == MODE_SPI_MASTER);
    assign active  = mode_on && TRANSMITTER_ENABLE;

    ////////////////////////////////////////////////////////////////////////////////
    // baud divisor register, zero after reset, low write reloads prescaler
    always_comb begin
        baud_d = baud_q;
        if (BAUD_WR_HIGH) begin
            baud_d[BAUD_W-1:BAUD_LO_W] = BAUD_WDATA[BAUD_HI_W-1:0];
        end
        if (BAUD_WR_LOW) begin
            baud_d[BAUD_LO_W-1:0] = BAUD_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            baud_q   <= BAUD_RESET;
            reload_q <= 1'b0;
        end else if (CLK_EN) begin
            baud_q   <= baud_d;
            reload_q <= BAUD_WR_LOW;
        end
    end

    // higher rates come only from a smaller divisor
    spim_baud_gen u_baud (
        .clk    (CORE_CLK),
        .rst_n  (RST_N),
        .clk_en (CLK_EN),
        .baud   (baud_q),
        .reload (reload_q),
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // transfer control: transmit buffer, shifters, serial clock and completion flag
    always_comb begin
        state_d  = state_q;
        edge_d   = edge_q;
        tx_sh_d  = tx_sh_q;
        rx_sh_d  = rx_sh_q;
        txbuf_d  = txbuf_q;
        txfull_d = txfull_q;
        txc_d    = txc_q;
        sclk_d   = sclk_q;
        sdo_d    = sdo_q;
        push     = 1'b0;
        load     = 1'b0;
        leading  = ~edge_q[0];
        sample   = leading ^ CLOCK_PHASE_BIT;
        if (TXC_CLEAR) begin
            txc_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
                sclk_d = CLOCK_POLARITY_BIT;
                sdo_d  = 1'b1;
                edge_d = FIRST_EDGE;
                load   = active && txfull_q;
            end
            ST_SHIFT: begin
                if (!mode_on) begin
                    state_d = ST_IDLE;
                    sdo_d   = 1'b1;
                end else if (tick) begin
                    sclk_d = ~sclk_q;
                    edge_d = edge_q + EDGE_STEP;
                    if (sample) begin
                        rx_sh_d = shift_in(rx_sh_q, SERIAL_IN_PIN, BIT_ORDER_SELECT);
                    end else if (CLOCK_PHASE_BIT && edge_q == FIRST_EDGE) begin
                        sdo_d = first_bit(tx_sh_q, BIT_ORDER_SELECT);
                    end else if (edge_q != LAST_EDGE) begin
                        tx_sh_d = shift_out(tx_sh_q, BIT_ORDER_SELECT);
                        sdo_d   = first_bit(tx_sh_d, BIT_ORDER_SELECT);
                    end
                    if (edge_q == LAST_EDGE) begin
                        // sixteen edges close the eight-bit frame
                        push = RECEIVER_ENABLE;
                        if (active && txfull_q) begin
                            load = 1'b1;
                        end else begin
                            // data line holds through the last sample edge; idle drives it high next cycle
                            state_d = ST_IDLE;
                            txc_d   = 1'b1;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // queued byte moves into the free shifter
        if (load) begin
            tx_sh_d  = txbuf_q;
            txfull_d = 1'b0;
            state_d  = ST_SHIFT;
            edge_d   = FIRST_EDGE;
            sdo_d    = CLOCK_PHASE_BIT ? sdo_d : first_bit(txbuf_q, BIT_ORDER_SELECT);
        end
        // second buffer level accepts a write while shifting
        if (DATA_WRITE && active && !txfull_q) begin
            txbuf_d  = DATA_WDATA;
            txfull_d = 1'b1;
        end
        if (!mode_on || !TRANSMITTER_ENABLE) begin
            txfull_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_q  <= ST_IDLE;
            edge_q   <= FIRST_EDGE;
            tx_sh_q  <= BYTE_RESET;
            rx_sh_q  <= BYTE_RESET;
            txbuf_q  <= BYTE_RESET;
            txfull_q <= 1'b0;
            txc_q    <= 1'b0;
            sclk_q   <= 1'b0;
            sdo_q    <= 1'b1;
        end else if (CLK_EN) begin
            state_q  <= state_d;
            edge_q   <= edge_d;
            tx_sh_q  <= tx_sh_d;
            rx_sh_q  <= rx_sh_d;
            txbuf_q  <= txbuf_d;
            txfull_q <= txfull_d;
            txc_q    <= txc_d;
            sclk_q   <= sclk_d;
            sdo_q    <= sdo_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive buffer, flushed while the receiver is off
    spim_rx_buffer u_rxbuf (
        .clk       (CORE_CLK),
        .rst_n     (RST_N),
        .clk_en    (CLK_EN),
        .flush     (!RECEIVER_ENABLE),
        .push      (push),
        .push_data (rx_sh_d),
        .pop       (DATA_READ),
        .head      (DATA_RDATA),
        .not_empty (RECEIVE_COMPLETE_FLAG)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pin takeover and status flags, all registered
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            out_oe_q <= 1'b0;
            in_sel_q <= 1'b0;
            clk_oe_q <= 1'b0;
            udre_q   <= 1'b1;
            err_q    <= 1'b0;
        end else if (CLK_EN) begin
            out_oe_q <= active;
            in_sel_q <= mode_on && RECEIVER_ENABLE;
            clk_oe_q <= mode_on && CLOCK_PIN_DIRECTION;
            udre_q   <= !txfull_d;
            err_q    <= 1'b0;
        end
    end

    assign SERIAL_OUT_PIN         = sdo_q;
    assign SERIAL_OUT_OE          = out_oe_q;
    assign SERIAL_IN_SELECT       = in_sel_q;
    assign TRANSFER_CLOCK_PIN     = sclk_q;
    assign TRANSFER_CLOCK_OE      = clk_oe_q;
    assign TRANSMIT_COMPLETE_FLAG = txc_q;
    assign DATA_REG_EMPTY_FLAG    = udre_q;
    assign FRAMING_ERROR_FLAG     = err_q;
    assign OVERRUN_ERROR_FLAG     = err_q;
    assign PARITY_ERROR_FLAG      = err_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_error_flags_zero : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !(FRAMING_ERROR_FLAG || OVERRUN_ERROR_FLAG || PARITY_ERROR_FLAG))
        else $error("error flag read nonzero");

    a_idle_line_high : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == ST_IDLE && $past(state_q) == ST_IDLE) |-> sdo_q)
        else $error("data line not idle high between frames");

    a_idle_no_clock : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && state_q == ST_IDLE && !load) |=> (sclk_q == $past(CLOCK_POLARITY_BIT)))
        else $error("serial clock moved with no transfer");

    a_frame_end_level : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && state_q == ST_SHIFT && mode_on && tick && edge_q == LAST_EDGE)
            |=> (sclk_q == CLOCK_POLARITY_BIT))
        else $error("frame did not end with clock at idle level");

    a_txc_after_frame : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(txc_q) |-> ($past(state_q) == ST_SHIFT && !$past(txfull_q) && state_q == ST_IDLE))
        else $error("completion flag set while data still queued");

    a_load_when_free : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && state_q == ST_IDLE && active && txfull_q)
            |=> (state_q == ST_SHIFT && tx_sh_q == $past(txbuf_q) && edge_q == FIRST_EDGE))
        else $error("buffered byte not moved to shifter");

    a_txc_set_wins : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && TXC_CLEAR && state_q == ST_SHIFT && mode_on && tick && edge_q == LAST_EDGE && !load)
            |=> txc_q)
        else $error("completion lost against a clear");

    a_baud_after_reset : assert property (@(posedge CORE_CLK)
        !RST_N |=> (baud_q == BAUD_RESET))
        else $error("baud divisor not zero after reset");

    a_pin_takeover : assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN ##1 CLK_EN) |-> (SERIAL_OUT_OE == $past(active)
            && SERIAL_IN_SELECT == $past(mode_on && RECEIVER_ENABLE)))
        else $error("pin takeover does not follow enables");

endmodule

`default_nettype wire

// *** verification/spi_slave_model.sv ***
// Purpose: behavioural slave on the far side of the serial link
// Assumes: slave uses the same polarity, phase and bit order as the master
// Notes:   first frame answers seed, each later frame the inverse of the byte just received
`default_nettype none

module spi_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsb,
    input  wire logic       load,
    input  wire logic [7:0] seed,
    output var  logic       miso,
    output var  logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sh    = 8'h00;
    logic       fresh = 1'b1;
    int         n     = 0;

    // head bit of the answer, same order as the master
    assign miso = lsb ? sh[0] : sh[7];

    // start a new answer
    always @(posedge load) begin
        sh = seed;
        n = 0;
        fresh = cpha; // only a leading setup edge must leave the first bit in place
    end

    // sample on one clock edge, shift the answer on the other
    always @(sck) begin
        if ((sck != cpol) != cpha) begin
            got = lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
            n = n + 1;
            if (n == 8) begin
                sh = ~got;
                n = 0;
                fresh = 1'b1;
            end
        end else if (fresh) begin
            fresh = 1'b0;
        end else begin
            sh = lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
        end
    end
endmodule

`default_nettype wire

// *** verification/usart_master_spi_mode_tb_top.sv ***
// Purpose: self-checking bench for the master-only serial SPI engine
// Assumes: inputs move 1 ns after the rising clock edge
// Notes:   each scenario task drives the engine and judges the answer
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, a); end end

module usart_master_spi_mode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, rst_n = 0, txen = 1, rxen = 1, lsb = 0, cpol = 0, cpha = 0, cdir = 1;
    logic       bwl = 0, bwh = 0, dw = 0, dr = 0, txcc = 0, ld = 0;
    logic [7:0] bd = 0, wd = 0, seed = 8'h1e;
    logic [1:0] msel = 2'b11;
    logic [7:0] rd, got;
    logic       rxc, txc, udre, frm_err, ovr_err, par_err, sdo, sdo_oe, sin_sel, sck, sck_oe, miso;
    int         n_mismatch = 0, total_checks = 0, ne = 0, cycles = 0;
    realtime    t0;

    spim_top dut_u (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .PORT_MODE_SELECT(msel),
        .TRANSMITTER_ENABLE(txen), .RECEIVER_ENABLE(rxen), .BIT_ORDER_SELECT(lsb),
        .CLOCK_POLARITY_BIT(cpol), .CLOCK_PHASE_BIT(cpha), .CLOCK_PIN_DIRECTION(cdir),
        .BAUD_WR_LOW(bwl), .BAUD_WR_HIGH(bwh), .BAUD_WDATA(bd), .DATA_WRITE(dw), .DATA_WDATA(wd),
        .DATA_READ(dr), .TXC_CLEAR(txcc), .SERIAL_IN_PIN(miso), .DATA_RDATA(rd),
        .RECEIVE_COMPLETE_FLAG(rxc), .TRANSMIT_COMPLETE_FLAG(txc), .DATA_REG_EMPTY_FLAG(udre),
        .FRAMING_ERROR_FLAG(frm_err), .OVERRUN_ERROR_FLAG(ovr_err), .PARITY_ERROR_FLAG(par_err),
        .SERIAL_OUT_PIN(sdo), .SERIAL_OUT_OE(sdo_oe), .SERIAL_IN_SELECT(sin_sel),
        .TRANSFER_CLOCK_PIN(sck), .TRANSFER_CLOCK_OE(sck_oe));

    spi_slave_model slave_u (.sck(sck), .mosi(sdo), .cpol(cpol), .cpha(cpha), .lsb(lsb),
        .load(ld), .seed(seed), .miso(miso), .got(got));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, edge count and hang guard
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge sck) ne++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task send(input logic [7:0] b);
        for (int i = 0; i < 300 && udre !== 1'b1; i++) cyc(1);
        dw = 1;
        wd = b;
        cyc(1);
        dw = 0;
        cyc(2);
    endtask
    task wtx;
        for (int i = 0; i < 3000 && txc !== 1'b1; i++) cyc(1);
        `CHK("txc", 1'b1, txc)
        cyc(3);
    endtask
    task rd_chk(input string nm, input logic [7:0] e);
        `CHK(nm, e, rd)
        dr = 1;
        cyc(1);
        dr = 0;
        cyc(2);
    endtask
    task setup(input logic [2:0] k);
        cpha = k[0];
        cpol = k[1];
        lsb = k[2];
        txcc = 1;
        cyc(1);
        txcc = 0;
        cyc(2);
        ld = 1;
        cyc(1);
        ld = 0;
        ne = 0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task t_reset;
        `CHK("udre", 1'b1, udre)
        `CHK("txc", 1'b0, txc)
        `CHK("errs", 3'h0, {frm_err, ovr_err, par_err})
        `CHK("sdo", 1'b1, sdo)
        ne = 0;
        cyc(40);
        `CHK("idle edges", 0, ne)
        $display("test reset done");
    endtask
    task t_modes;
        logic [7:0] tx;
        for (int k = 0; k < 8; k++) begin
            tx = 8'h5c ^ 8'(k * 37);
            setup(3'(k));
            send(tx);
            wtx();
            `CHK("slave got", tx, got)
            `CHK("clocks", 8, ne)
            `CHK("sdo idle", 1'b1, sdo)
            `CHK("sck idle", cpol, sck)
            rd_chk("rx byte", seed);
        end
        $display("test modes done");
    endtask
    task t_b2b;
        setup(3'h0);
        send(8'h81);
        send(8'h42);
        send(8'h24);
        wtx();
        `CHK("clocks", 24, ne)
        `CHK("slave got", 8'h24, got)
        rd_chk("rx first", seed);
        rd_chk("rx second", 8'h7e);
        `CHK("rxc empty", 1'b0, rxc)
        `CHK("errs", 3'h0, {frm_err, ovr_err, par_err})
        $display("test queue done");
    endtask
    task t_baud;
        for (int d = 0; d < 4; d += 3) begin
            if (d > 0) begin
                bwh = 1;
                cyc(1);
                bwh = 0;
                bd = 8'(d);
                bwl = 1;
                cyc(1);
                bwl = 0;
            end
            setup(3'h0);
            send(8'h99);
            @(posedge sck) t0 = $realtime;
            @(negedge sck);
            `CHK("half period", (d + 1) * 10, int'($realtime - t0))
            wtx();
            rd_chk("rx", seed);
        end
        bd = 0;
        bwl = 1;
        cyc(1);
        bwl = 0;
        $display("test baud done");
    endtask
    task t_pins;
        `CHK("out oe", 1'b1, sdo_oe)
        `CHK("in sel", 1'b1, sin_sel)
        `CHK("clk oe", 1'b1, sck_oe)
        rxen = 0;
        cdir = 0;
        cyc(3);
        `CHK("in sel off", 1'b0, sin_sel)
        `CHK("clk oe off", 1'b0, sck_oe)
        cdir = 1;
        setup(3'h0);
        txcc = 1;
        send(8'h3c);
        wtx();
        txcc = 0;
        `CHK("txc held clear", 1'b0, txc)
        `CHK("tx only clocks", 8, ne)
        `CHK("rxc", 1'b0, rxc)
        txen = 0;
        rxen = 1;
        cyc(3);
        `CHK("out oe off", 1'b0, sdo_oe)
        ne = 0;
        dw = 1;
        cyc(1);
        dw = 0;
        cyc(40);
        `CHK("no tx clocks", 0, ne)
        txen = 1;
        msel = 2'b10;
        cyc(3);
        `CHK("mode off oe", 1'b0, sdo_oe)
        msel = 2'b11;
        cyc(3);
        $display("test pins done");
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // reset with transmitter on and divisor still zero, then run the scenarios
    initial begin
        cyc(16);
        rst_n = 1;
        cyc(2);
        t_reset();
        t_modes();
        t_b2b();
        t_baud();
        t_pins();
        stop_test();
    end
endmodule

`default_nettype wire
